/* File: sata_sb_pkg.sv */
/*
 * constants shared by both ends of the sideband, recovery and identify link.
 * assumes one 25 MHz core clock (ref_clk) and an active-low async reset (nrst).
 */
package sata_sb_pkg;

	// ==========================================================
	// identify data layout
	localparam int unsigned   ID_WORDS      = 256;
	localparam logic [7:0]    ID_LAST_IDX   = 8'hff;
	localparam logic [7:0]    ID_SIG_BYTE   = 8'ha5;

	// ==========================================================
	// shadow register values seen by the host
	localparam logic [7:0]    SH_NUM        = 8'h06;
	localparam logic [7:0]    SH_UNSOL_STAT = 8'h7f;
	localparam logic [7:0]    SH_UNSOL_OTH  = 8'hff;
	localparam logic [7:0]    SH_ATT_STAT   = 8'h80;
	localparam logic [7:0]    SH_RST_VAL    = 8'h00;

	// sideband idles high through the backplane pull-up
	localparam logic          SB_PULL_LVL   = 1'b1;

	// ==========================================================
	// device recovery sequence
	typedef enum logic [1:0] {
		REC_IDLE = 2'b00,
		REC_WAIT = 2'b01,
		REC_SIG  = 2'b11
	} rec_state_e;

endpackage

/* File: sata_sb_if.sv */
/*
 * link between the device end and the host end.
 * resolves the shared sideband wire from both enables; the bench joins both ends here.
 */
interface sata_sb_if
	import sata_sb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst
);
	logic        sb_dev_o;
	logic        sb_dev_oe;
	logic        sb_host_o;
	logic        sb_host_oe;
	logic        sb_lvl;
	logic        cominit;
	logic        comreset;
	logic        oob_done;
	logic        sig;
	logic        id_req;
	logic        id_vld;
	logic        id_last;
	logic [15:0] id_data;

	// device wins a clash; a well-behaved host never drives after ready
	assign sb_lvl = sb_dev_oe ? sb_dev_o : (sb_host_oe ? sb_host_o : SB_PULL_LVL);

	modport dev (
		input  ref_clk, nrst, sb_lvl, comreset, oob_done, id_req,
		output sb_dev_o, sb_dev_oe, cominit, sig, id_vld, id_last, id_data
	);
	modport host (
		input  ref_clk, nrst, sb_lvl, cominit, sig, id_vld, id_last, id_data,
		output sb_host_o, sb_host_oe, comreset, oob_done, id_req
	);
endinterface

/* File: sata_sb_dev.sv */
/*
 * device end: sideband pin role switch, loss/recovery tracking,
 * device-started recovery with signature, and the identify word stream.
 * assumes link_rdy is the device phy ready level, synchronous to ref_clk.
 */
module sata_sb_dev
	import sata_sb_pkg::*;
(
	sata_sb_if.dev    lnk,
	input  wire logic link_rdy,
	input  wire logic activity,
	input  wire logic recover_req,
	output logic      stagger_spinup,
	output logic      loss_of_signal,
	output logic      signal_recovered
);

	// ==========================================================
	// identify contents
	function automatic logic [15:0] id_lookup(input logic [7:0] idx);
		logic [15:0] w;
		w = 16'h0000;
		case (idx)
			8'd0:   w = 16'h0040;
			8'd1:   w = 16'h3fff;
			8'd2:   w = 16'hc837;
			8'd3:   w = 16'h0010;
			8'd6:   w = 16'h003f;
			8'd22:  w = 16'h0004;
			8'd47:  w = 16'h8010;
			8'd49:  w = 16'h2f00;
			8'd50:  w = 16'h4000;
			8'd51:  w = 16'h0200;
			8'd53:  w = 16'h0007;
			8'd54:  w = 16'h3fff;
			8'd55:  w = 16'h0010;
			8'd56:  w = 16'h003f;
			8'd57:  w = 16'hfc10;
			8'd58:  w = 16'h00bf;
			8'd59:  w = 16'h0110;
			8'd63:  w = 16'h0007;
			8'd64:  w = 16'h0003;
			8'd65:  w = 16'h0078;
			8'd66:  w = 16'h0078;
			8'd67:  w = 16'h0078;
			8'd68:  w = 16'h0078;
			8'd76:  w = 16'h0606;
			8'd78:  w = 16'h0048;
			8'd79:  w = 16'h0040;
			8'd80:  w = 16'h00fc;
			8'd81:  w = 16'h001a;
			8'd82:  w = 16'h746b;
			8'd83:  w = 16'h7d01;
			8'd84:  w = 16'h4163;
			8'd85:  w = 16'h7469;
			8'd86:  w = 16'h3c01;
			8'd87:  w = 16'h4163;
			8'd88:  w = 16'h203f;
			8'd89:  w = 16'h0003;
			8'd90:  w = 16'h0003;
			8'd92:  w = 16'hfffe;
			8'd128: w = 16'h0021;
			8'd217: w = 16'h0001;
			8'd234: w = 16'h0000;
			8'd235: w = 16'h0080;
			// serial, firmware, model and capacity words ship blank here
			default: w = 16'h0000;
		endcase
		return w;
	endfunction

	// ==========================================================
	// sideband pin role
	logic stagger_q;
	logic act_q;

	// latch the host level only while the pin is still an input
	always_ff @(posedge lnk.ref_clk or negedge lnk.nrst) begin
		if (!lnk.nrst) begin
			stagger_q <= 1'b0;
		end else if (!link_rdy) begin
			stagger_q <= lnk.sb_lvl;
		end
	end

	always_ff @(posedge lnk.ref_clk or negedge lnk.nrst) begin
		if (!lnk.nrst) begin
			act_q <= 1'b0;
		end else begin
			act_q <= activity;
		end
	end

	// drives only after ready, so a spin-up strap is never fought
	assign lnk.sb_dev_oe = link_rdy;
	assign lnk.sb_dev_o  = act_q;
	assign stagger_spinup = stagger_q;

	// ==========================================================
	// loss and recovery of signal
	logic rdy_q;
	logic loss_q;
	logic recov_q;

	always_ff @(posedge lnk.ref_clk or negedge lnk.nrst) begin
		if (!lnk.nrst) begin
			rdy_q   <= 1'b0;
			loss_q  <= 1'b0;
			recov_q <= 1'b0;
		end else begin
			rdy_q   <= link_rdy;
			loss_q  <= rdy_q & ~link_rdy;
			recov_q <= ~rdy_q & link_rdy;
		end
	end

	assign loss_of_signal   = loss_q;
	assign signal_recovered = recov_q;

	// ==========================================================
	// cominit and signature
	rec_state_e rec_q;
	logic       cominit_q;
	logic       sig_q;

	always_ff @(posedge lnk.ref_clk or negedge lnk.nrst) begin
		if (!lnk.nrst) begin
			rec_q     <= REC_IDLE;
			cominit_q <= 1'b0;
			sig_q     <= 1'b0;
		end else begin
			cominit_q <= 1'b0;
			sig_q     <= 1'b0;
			case (rec_q)
				REC_IDLE: begin
					// own recovery attempt, or answer to a host reset
					if ((recover_req && !link_rdy) || lnk.comreset) begin
						cominit_q <= 1'b1;
						rec_q     <= REC_WAIT;
					end
				end
				REC_WAIT: begin
					if (lnk.comreset) begin
						cominit_q <= 1'b1;
					end else if (lnk.oob_done) begin
						rec_q <= REC_SIG;
					end
				end
				REC_SIG: begin
					sig_q <= 1'b1;
					rec_q <= REC_IDLE;
				end
				default: begin
					rec_q <= REC_IDLE;
				end
			endcase
		end
	end

	assign lnk.cominit = cominit_q;
	assign lnk.sig     = sig_q;

	// ==========================================================
	// identify stream
	logic        busy_q;
	logic [7:0]  idx_q;
	logic [7:0]  sum_q;
	logic        vld_q;
	logic        last_q;
	logic [15:0] data_q;
	logic [15:0] word;
	logic [7:0]  cks;

	// checksum closes the byte sum including the signature byte
	assign cks  = 8'h00 - sum_q - ID_SIG_BYTE;
	assign word = (idx_q == ID_LAST_IDX) ? {cks, ID_SIG_BYTE} : id_lookup(idx_q);

	always_ff @(posedge lnk.ref_clk or negedge lnk.nrst) begin
		if (!lnk.nrst) begin
			busy_q <= 1'b0;
			idx_q  <= 8'h00;
			sum_q  <= 8'h00;
			vld_q  <= 1'b0;
			last_q <= 1'b0;
			data_q <= 16'h0000;
		end else if (busy_q) begin
			vld_q  <= 1'b1;
			data_q <= word;
			sum_q  <= sum_q + word[15:8] + word[7:0];
			idx_q  <= idx_q + 8'h01;
			last_q <= (idx_q == ID_LAST_IDX);
			busy_q <= (idx_q != ID_LAST_IDX);
		end else begin
			vld_q  <= 1'b0;
			last_q <= 1'b0;
			// requests during a stream are ignored
			if (lnk.id_req) begin
				busy_q <= 1'b1;
				idx_q  <= 8'h00;
				sum_q  <= 8'h00;
			end
		end
	end

	assign lnk.id_vld  = vld_q;
	assign lnk.id_last = last_q;
	assign lnk.id_data = data_q;

endmodule // sata_sb_dev

/* File: sata_sb_host.sv */
/*
 * host end: sideband use (activity receive or spin-up disable), comreset,
 * shadow status load on cominit (whole block if unsolicited), identify request and capture.
 * assumes link_rdy is the host phy ready level, synchronous to ref_clk.
 */
module sata_sb_host
	import sata_sb_pkg::*;
(
	sata_sb_if.host     lnk,
	input  wire logic   link_rdy,
	input  wire logic   act_rx_en,
	input  wire logic   spinup_disable,
	input  wire logic   comreset_req,
	input  wire logic   identify_req,
	output logic        activity_seen,
	output logic        loss_of_signal,
	output logic        signal_recovered,
	output logic        signature_seen,
	output logic [7:0]  shadow_status,
	output logic [7:0]  shadow_other [SH_NUM],
	output logic        id_word_vld,
	output logic [15:0] id_word,
	output logic        id_done,
	output logic        id_sum_ok
);

	// ==========================================================
	// sideband: one purpose only
	logic act_q;

	// never drive while receiving activity, and never after ready
	assign lnk.sb_host_oe = ~act_rx_en & ~link_rdy;
	assign lnk.sb_host_o  = ~spinup_disable;

	always_ff @(posedge lnk.ref_clk or negedge lnk.nrst) begin
		if (!lnk.nrst) begin
			act_q <= 1'b0;
		end else begin
			act_q <= act_rx_en & link_rdy & lnk.sb_lvl;
		end
	end
	assign activity_seen = act_q;

	// ==========================================================
	// loss, recovery and reset handshake
	logic       rdy_q;
	logic       loss_q;
	logic       recov_q;
	logic       await_q;
	logic       comreset_q;
	logic       oob_q;
	logic       sig_q;
	logic [7:0] stat_q;
	logic [7:0] oth_q [SH_NUM];

	always_ff @(posedge lnk.ref_clk or negedge lnk.nrst) begin
		if (!lnk.nrst) begin
			rdy_q   <= 1'b0;
			loss_q  <= 1'b0;
			recov_q <= 1'b0;
			sig_q   <= 1'b0;
		end else begin
			rdy_q   <= link_rdy;
			loss_q  <= rdy_q & ~link_rdy;
			recov_q <= ~rdy_q & link_rdy;
			sig_q   <= lnk.sig;
		end
	end

	always_ff @(posedge lnk.ref_clk or negedge lnk.nrst) begin
		if (!lnk.nrst) begin
			await_q    <= 1'b0;
			comreset_q <= 1'b0;
			oob_q      <= 1'b0;
		end else begin
			comreset_q <= comreset_req & ~await_q;
			// the oob sequence closes the cycle after cominit lands
			oob_q      <= lnk.cominit;
			if (lnk.cominit) begin
				await_q <= 1'b0;
			end else if (comreset_req) begin
				await_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge lnk.ref_clk or negedge lnk.nrst) begin
		if (!lnk.nrst) begin
			stat_q <= SH_RST_VAL;
			oth_q  <= '{default: SH_RST_VAL};
		end else if (lnk.cominit) begin
			if (await_q) begin
				stat_q <= SH_ATT_STAT;
			end else begin
				stat_q <= SH_UNSOL_STAT;
				oth_q  <= '{default: SH_UNSOL_OTH};
			end
		end
	end

	assign lnk.comreset    = comreset_q;
	assign lnk.oob_done    = oob_q;
	assign loss_of_signal  = loss_q;
	assign signal_recovered = recov_q;
	assign signature_seen  = sig_q;
	assign shadow_status   = stat_q;
	assign shadow_other    = oth_q;

	// ==========================================================
	// identify capture with running byte sum
	logic        req_q;
	logic        wv_q;
	logic [15:0] w_q;
	logic        done_q;
	logic        ok_q;
	logic [7:0]  sum_q;
	logic [7:0]  sum_d;

	assign sum_d = sum_q + lnk.id_data[15:8] + lnk.id_data[7:0];

	always_ff @(posedge lnk.ref_clk or negedge lnk.nrst) begin
		if (!lnk.nrst) begin
			req_q  <= 1'b0;
			wv_q   <= 1'b0;
			w_q    <= 16'h0000;
			done_q <= 1'b0;
			ok_q   <= 1'b0;
			sum_q  <= 8'h00;
		end else begin
			req_q  <= identify_req;
			wv_q   <= lnk.id_vld;
			done_q <= lnk.id_vld & lnk.id_last;
			if (lnk.id_vld) begin
				w_q   <= lnk.id_data;
				sum_q <= lnk.id_last ? 8'h00 : sum_d;
				if (lnk.id_last) begin
					ok_q <= (sum_d == 8'h00);
				end
			end
		end
	end

	assign lnk.id_req  = req_q;
	assign id_word_vld = wv_q;
	assign id_word     = w_q;
	assign id_done     = done_q;
	assign id_sum_ok   = ok_q;

endmodule // sata_sb_host

/* File: sata_sb_asserts.sv */
/*
 * assertions on the device/host link.
 * assumes instantiation beside the interface, fed its signals by name.
 */
module sata_sb_asserts (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        sb_dev_o,
	input wire logic        sb_dev_oe,
	input wire logic        sb_host_oe,
	input wire logic        sb_lvl,
	input wire logic        cominit,
	input wire logic        comreset,
	input wire logic        oob_done,
	input wire logic        sig,
	input wire logic        id_vld,
	input wire logic        id_last,
	input wire logic [15:0] id_data
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] cnt_q;

	// ==========
	// word index of the identify stream
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 8'h00;
		end else if (id_vld) begin
			cnt_q <= id_last ? 8'h00 : cnt_q + 8'h01;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// ==========
	// properties
	a_pin_owner: assert property (
		sb_dev_oe |-> !sb_host_oe && sb_lvl == sb_dev_o) else $error("sideband clash");
	a_reset_answer: assert property (
		comreset && !id_vld |=> cominit) else $error("no cominit on comreset");
	a_oob_follow: assert property (
		cominit |=> oob_done) else $error("no oob done");
	a_sig_after: assert property (
		oob_done |-> ##2 sig) else $error("no signature");
	a_sig_single: assert property (
		sig |=> !sig) else $error("signature too long");
	a_no_gap: assert property (
		id_vld && !id_last |=> id_vld) else $error("gap in stream");
	a_stream_len: assert property (
		id_last |-> id_vld && cnt_q == 8'hff) else $error("bad stream length");
	a_geom_word: assert property (
		id_vld && cnt_q == 8'h01 |-> id_data == 16'h3fff) else $error("bad cylinders");
	a_ssd_word: assert property (
		id_vld && cnt_q == 8'hd9 |-> id_data == 16'h0001) else $error("bad rotation");

	cover property (cominit);
	cover property (id_last);
	cover property (sb_dev_oe && sb_dev_o);
endmodule // sata_sb_asserts

/* File: sata_sideband_recovery_identify_tb_top.sv */
/*
 * self-checking bench joining device and host ends.
 * assumes the design files and package are compiled first.
 */
module sata_sideband_recovery_identify_tb_top
	import sata_sb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        rdy = 1'b0;
	logic        act = 1'b0;
	logic        rreq = 1'b0;
	logic        act_rx = 1'b0;
	logic        sp_dis = 1'b0;
	logic        cr_req = 1'b0;
	logic        idr = 1'b0;
	logic        stag, d_los, d_rec, a_seen, h_los, h_rec, sg_seen;
	logic        w_vld, i_done, sum_ok;
	logic [7:0]  sh_st;
	logic [7:0]  sh_ot [SH_NUM];
	logic [15:0] w;
	logic [16:0] e;
	int          err_total, compares, nw, sum;
	int unsigned rs = 31;
	wire [1:0]   ev = {i_done, sg_seen};

	always #20 ref_clk = ~ref_clk;

	sata_sb_if lnk (.ref_clk(ref_clk), .nrst(nrst));
	sata_sb_dev u_sata_sb_dev (.lnk(lnk.dev), .link_rdy(rdy), .activity(act),
		.recover_req(rreq), .stagger_spinup(stag), .loss_of_signal(d_los),
		.signal_recovered(d_rec));
	sata_sb_host u_sata_sb_host (.lnk(lnk.host), .link_rdy(rdy), .act_rx_en(act_rx),
		.spinup_disable(sp_dis), .comreset_req(cr_req), .identify_req(idr),
		.activity_seen(a_seen), .loss_of_signal(h_los), .signal_recovered(h_rec),
		.signature_seen(sg_seen), .shadow_status(sh_st), .shadow_other(sh_ot),
		.id_word_vld(w_vld), .id_word(w), .id_done(i_done), .id_sum_ok(sum_ok));
	sata_sb_asserts u_sata_sb_asserts (.ref_clk(ref_clk), .nrst(nrst),
		.sb_dev_o(lnk.sb_dev_o), .sb_dev_oe(lnk.sb_dev_oe), .sb_host_oe(lnk.sb_host_oe),
		.sb_lvl(lnk.sb_lvl), .cominit(lnk.cominit), .comreset(lnk.comreset),
		.oob_done(lnk.oob_done), .sig(lnk.sig), .id_vld(lnk.id_vld),
		.id_last(lnk.id_last), .id_data(lnk.id_data));

	// ==========
	// model and helpers
	function automatic logic rb();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[0];
	endfunction

	// bit 16 marks a word whose value is fixed
	function automatic logic [16:0] ew(int i);
		case (i) inside
			0, 79: ew = 17'h10040;
			1, 54: ew = 17'h13fff;
			3, 55: ew = 17'h10010;
			6, 56: ew = 17'h1003f;
			47: ew = 17'h18010;
			59: ew = 17'h10110;
			[65:68]: ew = 17'h10078;
			76: ew = 17'h10606;
			78: ew = 17'h10048;
			82: ew = 17'h1746b;
			83: ew = 17'h17d01;
			84, 87: ew = 17'h14163;
			85: ew = 17'h17469;
			86: ew = 17'h13c01;
			217: ew = 17'h10001;
			235: ew = 17'h10080;
			4, 5, 7, 8, 48, 77, 234, [129:159], [236:254]: ew = 17'h10000;
			default: ew = 17'h00000;
		endcase
	endfunction

	task automatic summarize();
		if (err_total == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(logic [15:0] got, logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic step();
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic wt(int b);
		int k;
		for (k = 0; k < 400 && ev[b] !== 1'b1; k++) @(negedge ref_clk);
		if (k == 400) begin
			err_total++;
			summarize();
		end
	endtask

	always @(negedge ref_clk) begin
		if (w_vld === 1'b1) begin
			e = ew(nw);
			if (e[16]) chk(w, e[15:0]);
			sum += w[15:8] + w[7:0];
			nw++;
		end
	end

	// ==========
	// scenarios
	initial begin
		int k;
		logic v;
		logic [1:0] h;
		h = 2'b00;
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		sp_dis <= 1'b1;
		step();
		chk(stag, 1'b0);
		@(posedge ref_clk);
		act_rx <= 1'b1;
		step();
		chk(stag, 1'b1);
		chk(lnk.sb_host_oe, 1'b0);
		@(posedge ref_clk);
		rdy <= 1'b1;
		step();
		chk({d_rec, h_rec}, 2'b11);
		for (k = 0; k < 12; k++) begin
			@(posedge ref_clk);
			v = rb();
			act <= v;
			@(negedge ref_clk);
			if (k > 1) chk(a_seen, h[1]);
			chk(stag, 1'b1);
			h = {h[0], v};
		end
		@(posedge ref_clk);
		rdy <= 1'b0;
		step();
		chk({d_los, h_los}, 2'b11);
		@(negedge ref_clk);
		chk({d_los, h_los}, 2'b00);
		@(posedge ref_clk);
		rreq <= 1'b1;
		@(posedge ref_clk);
		rreq <= 1'b0;
		wt(0);
		chk(sh_st, 8'h7f);
		for (k = 0; k < SH_NUM; k++) chk(sh_ot[k], 8'hff);
		@(posedge ref_clk);
		cr_req <= 1'b1;
		@(posedge ref_clk);
		cr_req <= 1'b0;
		wt(0);
		chk(sh_st, 8'h80);
		// second pass starts right after the first; mid-stream request must be ignored
		for (k = 0; k < 2; k++) begin
			nw = 0;
			sum = 0;
			@(posedge ref_clk);
			idr <= 1'b1;
			@(posedge ref_clk);
			idr <= 1'b0;
			repeat (9) @(posedge ref_clk);
			idr <= 1'b1;
			@(posedge ref_clk);
			idr <= 1'b0;
			wt(1);
			@(negedge ref_clk);
			chk(nw[15:0], 16'h0100);
			chk(sum[7:0], 8'h00);
			chk(sum_ok, 1'b1);
		end
		summarize();
	end
endmodule // sata_sideband_recovery_identify_tb_top
